// File: design/spio_pkg.sv
/*
  Constants shared by the shared-pin parallel I/O ports: port indices, register
  selects, implemented-bit masks and the pin positions taken by each peripheral.
  Assumes every port is carried in an 8-bit lane and that narrower ports use the low bits.
*/
package spio_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int         NUM_PORTS = 6;
  localparam int         PORT_W    = 8;

  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_G = 3'h5;

  localparam logic [7:0] MASK_A = 8'hff;
  localparam logic [7:0] MASK_B = 8'hff;
  localparam logic [7:0] MASK_C = 8'hff;
  localparam logic [7:0] MASK_D = 8'h1f;
  localparam logic [7:0] MASK_E = 8'h3f;
  localparam logic [7:0] MASK_G = 8'h0f;

  // bits that always read the pad level, even as outputs
  localparam logic [7:0] READ_PIN_G = 8'h01;
  localparam logic [7:0] READ_PIN_NONE = 8'h00;

  // ----------------------------------------------------------------
  // register selects and reset value
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_DATA   = 2'h0;
  localparam logic [1:0] REG_DIR    = 2'h1;
  localparam logic [1:0] REG_PULLUP = 2'h2;
  localparam logic [1:0] REG_SLEW   = 2'h3;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int SER_TX_BIT    = 0;
  localparam int SER_RX_BIT    = 1;
  localparam int I2C_SDA_BIT   = 2;
  localparam int I2C_SCL_BIT   = 3;
  localparam int TMR2_LO_BIT   = 3;
  localparam int TMR2_CLK_BIT  = 3;
  localparam int TMR1_LO_BIT   = 0;
  localparam int TMR1_CLK_BIT  = 0;
  localparam int SPI_LO_BIT    = 2;
  localparam int BKGD_BIT      = 0;
  localparam int OSC_LO_BIT    = 1;

  function automatic logic [7:0] port_mask(input int p);
    case (p)
      0:       port_mask = MASK_A;
      1:       port_mask = MASK_B;
      2:       port_mask = MASK_C;
      3:       port_mask = MASK_D;
      4:       port_mask = MASK_E;
      5:       port_mask = MASK_G;
      default: port_mask = 8'h00;
    endcase
  endfunction

endpackage

// File: design/spio_port.sv
/*
  One parallel port: data latch, direction, pullup-enable and slew-enable storage,
  read selection, and the pad control once a peripheral may have taken the pin.
  Assumes the parent gives one-cycle write strobes and decodes peripheral ownership.
*/
`timescale 1ns/1ns

module spio_port #(
  parameter logic [7:0] IMPL_MASK     = 8'hff,
  parameter logic [7:0] READ_PIN_MASK = 8'h00
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register access
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_sel,
  output logic      [7:0] rd_data,
  // peripheral side
  input  wire logic [7:0] periph_own,
  input  wire logic [7:0] periph_oe,
  input  wire logic [7:0] periph_out,
  input  wire logic [7:0] pullup_force,
  // pad side
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pin_pullup_en,
  output logic      [7:0] pin_slew_en
);

  initial begin
    if (IMPL_MASK == 8'h00) begin
      $error("port needs at least one implemented bit");
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] data_q, data_d;
  logic [7:0] dir_q,  dir_d;
  logic [7:0] pe_q,   pe_d;
  logic [7:0] se_q,   se_d;

  always_comb begin
    data_d = data_q;
    dir_d  = dir_q;
    pe_d   = pe_q;
    se_d   = se_q;
    if (wr_en) begin
      // unimplemented bits never store anything
      case (wr_sel)
        spio_pkg::REG_DATA:   data_d = wr_data & IMPL_MASK;
        spio_pkg::REG_DIR:    dir_d  = wr_data & IMPL_MASK;
        spio_pkg::REG_PULLUP: pe_d   = wr_data & IMPL_MASK;
        spio_pkg::REG_SLEW:   se_d   = wr_data & IMPL_MASK;
        default:              data_d = data_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= spio_pkg::REG_RESET;
      dir_q  <= spio_pkg::REG_RESET;
      pe_q   <= spio_pkg::REG_RESET;
      se_q   <= spio_pkg::REG_RESET;
    end else begin
      data_q <= data_d;
      dir_q  <= dir_d;
      pe_q   <= pe_d;
      se_q   <= se_d;
    end
  end

  // ----------------------------------------------------------------
  // read and pad control
  // ----------------------------------------------------------------
  logic [7:0] rd_sel_pin;

  always_comb begin
    // direction picks latch or pad even while a peripheral owns the pin
    rd_sel_pin = ~dir_q | READ_PIN_MASK;
    case (rd_sel)
      spio_pkg::REG_DATA:   rd_data = ((pin_in & rd_sel_pin) | (data_q & ~rd_sel_pin)) & IMPL_MASK;
      spio_pkg::REG_DIR:    rd_data = dir_q;
      spio_pkg::REG_PULLUP: rd_data = pe_q;
      spio_pkg::REG_SLEW:   rd_data = se_q;
      default:              rd_data = 8'h00;
    endcase
  end

  always_comb begin
    pin_oe        = ((periph_own & periph_oe) | (~periph_own & dir_q)) & IMPL_MASK;
    pin_out       = ((periph_own & periph_out) | (~periph_own & data_q)) & IMPL_MASK;
    pin_pullup_en = ((pe_q & ~pin_oe) | pullup_force) & IMPL_MASK;
    pin_slew_en   = se_q & pin_oe;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  latch_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && wr_sel == spio_pkg::REG_DATA |=> data_q == ($past(wr_data) & IMPL_MASK))
    else $error("data write did not reach the output latch");

  gpio_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_oe & ~periph_own) == (dir_q & ~periph_own & IMPL_MASK))
    else $error("general-purpose driver enabled against direction or ownership");

  pullup_input_a: assert property (@(posedge clk) disable iff (!reset_n)
    ((pin_pullup_en & ~pullup_force) & pin_oe) == 8'h00)
    else $error("pullup enabled on a driven pin");

  slew_output_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_slew_en & ~pin_oe) == 8'h00)
    else $error("slew control active on an input pin");

endmodule

// File: design/spio_top.sv
/*
  Six shared-pin parallel I/O ports and their peripheral pin ownership.
  Assumes register access by one-cycle write strobes; reads answer one cycle after
  the read select, from a flop.
*/
// Notes on behaviour
// - enabled analog pins are always inputs
// - per-pin analog enables pick converter inputs
// - serial two or I2C own their pins
// - serial two: bit0 transmit, bit1 receive
// - I2C: bit2 data, bit3 clock
// - enabled timer channels own their pins
// - timer two bits 4-3, timer one 2-0
// - serial one or SPI own their pins
// - serial one: bit0 transmit, bit1 receive
// - SPI: select, master-in, master-out, clock on 2-5
// - background or oscillator own debug-port pins
// - background function forces bit0 pullup on
// - bit0: mode input in reset, then background
// - oscillator uses debug-port bits 2 and 1
// - unowned pins are general-purpose with four registers
// - data read: pad if input, latch if output
// - data writes always update the latch
// - latch drives only unowned output pins
// - direction still picks read source when owned
// - debug-port bit0 reads the pad level
// - reset clears direction and pullup enables
// - pullup only acts on input pins, except the forced debug-port bit0
// - slew only acts on output pins
`timescale 1ns/1ns

module spio_top (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // register access
  input  wire logic            reg_wr_en,
  input  wire logic [2:0]      reg_wr_port,
  input  wire logic [1:0]      reg_wr_sel,
  input  wire logic [7:0]      reg_wr_data,
  input  wire logic [2:0]      reg_rd_port,
  input  wire logic [1:0]      reg_rd_sel,
  output logic      [7:0]      reg_rd_data,
  // pads, index 0..5 = ports a, b, c, d, e, g
  input  wire logic [5:0][7:0] pin_in,
  output logic      [5:0][7:0] pin_out,
  output logic      [5:0][7:0] pin_oe,
  output logic      [5:0][7:0] pin_pullup_en,
  output logic      [5:0][7:0] pin_slew_en,
  // analog converter
  input  wire logic            analog_converter_en,
  input  wire logic [7:0]      analog_pin_en,
  // serial channel two and I2C
  input  wire logic            serial_channel_two_en,
  input  wire logic            serial_two_transmit,
  output logic                 serial_two_receive,
  input  wire logic            i2c_en,
  input  wire logic            i2c_sda_out,
  input  wire logic            i2c_sda_oe,
  input  wire logic            i2c_scl_out,
  input  wire logic            i2c_scl_oe,
  output logic                 i2c_sda_in,
  output logic                 i2c_scl_in,
  // timer units, one enable per channel
  input  wire logic [1:0]      timer_unit_two_en,
  input  wire logic [1:0]      timer_two_ch_out,
  input  wire logic [1:0]      timer_two_ch_oe,
  output logic      [1:0]      timer_two_ch_in,
  output logic                 timer_two_ext_clk,
  input  wire logic [2:0]      timer_unit_one_en,
  input  wire logic [2:0]      timer_one_ch_out,
  input  wire logic [2:0]      timer_one_ch_oe,
  output logic      [2:0]      timer_one_ch_in,
  output logic                 timer_one_ext_clk,
  // serial channel one and SPI; spi index 0..3 = select, master-in, master-out, clock
  input  wire logic            serial_channel_one_en,
  input  wire logic            serial_one_transmit,
  output logic                 serial_one_receive,
  input  wire logic            spi_en,
  input  wire logic [3:0]      spi_pin_out,
  input  wire logic [3:0]      spi_pin_oe,
  output logic      [3:0]      spi_pin_in,
  // background pin and oscillator
  input  wire logic            background_pin_enable,
  input  wire logic            background_out,
  input  wire logic            background_oe,
  output logic                 background_in,
  output logic                 mode_select_level,
  input  wire logic            clock_generator_en,
  input  wire logic [1:0]      osc_pin_out,
  input  wire logic [1:0]      osc_pin_oe,
  output logic      [1:0]      osc_pin_in
);

  // ----------------------------------------------------------------
  // reset phase and mode-select capture
  // ----------------------------------------------------------------
  logic running_q, running_d;
  logic mode_q,    mode_d;
  logic [7:0] rd_q, rd_d;
  logic [5:0][7:0] port_rd;

  always_comb begin
    running_d = 1'b1;
    // the strap is sampled once, on the first edge after release
    mode_d    = running_q ? mode_q : pin_in[spio_pkg::PORT_G][spio_pkg::BKGD_BIT];
    rd_d      = (reg_rd_port < 3'(spio_pkg::NUM_PORTS)) ? port_rd[reg_rd_port] : 8'h00;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      running_q <= 1'b0;
      mode_q    <= 1'b0;
      rd_q      <= 8'h00;
    end else begin
      running_q <= running_d;
      mode_q    <= mode_d;
      rd_q      <= rd_d;
    end
  end

  assign reg_rd_data       = rd_q;
  assign mode_select_level = mode_q;

  // ----------------------------------------------------------------
  // peripheral ownership
  // ----------------------------------------------------------------
  logic [5:0][7:0] own, poe, pout, pforce;
  logic            bkgd_own;

  always_comb begin
    own    = '0;
    poe    = '0;
    pout   = '0;
    pforce = '0;
    // analog pins are owned with the driver off, so they stay inputs
    if (analog_converter_en) begin
      own[spio_pkg::PORT_B] = analog_pin_en;
    end
    if (serial_channel_two_en) begin
      own[spio_pkg::PORT_C][spio_pkg::SER_TX_BIT]  = 1'b1;
      poe[spio_pkg::PORT_C][spio_pkg::SER_TX_BIT]  = 1'b1;
      pout[spio_pkg::PORT_C][spio_pkg::SER_TX_BIT] = serial_two_transmit;
      own[spio_pkg::PORT_C][spio_pkg::SER_RX_BIT]  = 1'b1;
    end
    if (i2c_en) begin
      own[spio_pkg::PORT_C][spio_pkg::I2C_SDA_BIT]  = 1'b1;
      poe[spio_pkg::PORT_C][spio_pkg::I2C_SDA_BIT]  = i2c_sda_oe;
      pout[spio_pkg::PORT_C][spio_pkg::I2C_SDA_BIT] = i2c_sda_out;
      own[spio_pkg::PORT_C][spio_pkg::I2C_SCL_BIT]  = 1'b1;
      poe[spio_pkg::PORT_C][spio_pkg::I2C_SCL_BIT]  = i2c_scl_oe;
      pout[spio_pkg::PORT_C][spio_pkg::I2C_SCL_BIT] = i2c_scl_out;
    end
    for (int i = 0; i < 2; i++) begin
      own[spio_pkg::PORT_D][spio_pkg::TMR2_LO_BIT + i]  = timer_unit_two_en[i];
      poe[spio_pkg::PORT_D][spio_pkg::TMR2_LO_BIT + i]  = timer_unit_two_en[i] & timer_two_ch_oe[i];
      pout[spio_pkg::PORT_D][spio_pkg::TMR2_LO_BIT + i] = timer_two_ch_out[i];
    end
    for (int i = 0; i < 3; i++) begin
      own[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT + i]  = timer_unit_one_en[i];
      poe[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT + i]  = timer_unit_one_en[i] & timer_one_ch_oe[i];
      pout[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT + i] = timer_one_ch_out[i];
    end
    if (serial_channel_one_en) begin
      own[spio_pkg::PORT_E][spio_pkg::SER_TX_BIT]  = 1'b1;
      poe[spio_pkg::PORT_E][spio_pkg::SER_TX_BIT]  = 1'b1;
      pout[spio_pkg::PORT_E][spio_pkg::SER_TX_BIT] = serial_one_transmit;
      own[spio_pkg::PORT_E][spio_pkg::SER_RX_BIT]  = 1'b1;
    end
    if (spi_en) begin
      for (int i = 0; i < 4; i++) begin
        own[spio_pkg::PORT_E][spio_pkg::SPI_LO_BIT + i]  = 1'b1;
        poe[spio_pkg::PORT_E][spio_pkg::SPI_LO_BIT + i]  = spi_pin_oe[i];
        pout[spio_pkg::PORT_E][spio_pkg::SPI_LO_BIT + i] = spi_pin_out[i];
      end
    end
    // while running_q is low the pin is a pure mode-select input
    own[spio_pkg::PORT_G][spio_pkg::BKGD_BIT]    = bkgd_own;
    poe[spio_pkg::PORT_G][spio_pkg::BKGD_BIT]    = running_q & background_oe;
    pout[spio_pkg::PORT_G][spio_pkg::BKGD_BIT]   = background_out;
    pforce[spio_pkg::PORT_G][spio_pkg::BKGD_BIT] = bkgd_own;
    if (clock_generator_en) begin
      for (int i = 0; i < 2; i++) begin
        own[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT + i]  = 1'b1;
        poe[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT + i]  = osc_pin_oe[i];
        pout[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT + i] = osc_pin_out[i];
      end
    end
  end

  assign bkgd_own = ~running_q | background_pin_enable;

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  for (genvar p = 0; p < spio_pkg::NUM_PORTS; p++) begin : g_port
    spio_port #(
      .IMPL_MASK     (spio_pkg::port_mask(p)),
      .READ_PIN_MASK ((p == spio_pkg::PORT_G) ? spio_pkg::READ_PIN_G : spio_pkg::READ_PIN_NONE)
    ) u_port (
      .clk           (clk),
      .reset_n       (reset_n),
      .wr_en         (reg_wr_en && (reg_wr_port == 3'(p))),
      .wr_sel        (reg_wr_sel),
      .wr_data       (reg_wr_data),
      .rd_sel        (reg_rd_sel),
      .rd_data       (port_rd[p]),
      .periph_own    (own[p]),
      .periph_oe     (poe[p]),
      .periph_out    (pout[p]),
      .pullup_force  (pforce[p]),
      .pin_in        (pin_in[p]),
      .pin_out       (pin_out[p]),
      .pin_oe        (pin_oe[p]),
      .pin_pullup_en (pin_pullup_en[p]),
      .pin_slew_en   (pin_slew_en[p])
    );
  end

  // ----------------------------------------------------------------
  // pad levels back to the peripherals
  // ----------------------------------------------------------------
  assign serial_two_receive = pin_in[spio_pkg::PORT_C][spio_pkg::SER_RX_BIT];
  assign i2c_sda_in         = pin_in[spio_pkg::PORT_C][spio_pkg::I2C_SDA_BIT];
  assign i2c_scl_in         = pin_in[spio_pkg::PORT_C][spio_pkg::I2C_SCL_BIT];
  assign timer_two_ch_in    = pin_in[spio_pkg::PORT_D][spio_pkg::TMR2_LO_BIT +: 2];
  assign timer_two_ext_clk  = pin_in[spio_pkg::PORT_D][spio_pkg::TMR2_CLK_BIT];
  assign timer_one_ch_in    = pin_in[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT +: 3];
  assign timer_one_ext_clk  = pin_in[spio_pkg::PORT_D][spio_pkg::TMR1_CLK_BIT];
  assign serial_one_receive = pin_in[spio_pkg::PORT_E][spio_pkg::SER_RX_BIT];
  assign spi_pin_in         = pin_in[spio_pkg::PORT_E][spio_pkg::SPI_LO_BIT +: 4];
  assign background_in      = pin_in[spio_pkg::PORT_G][spio_pkg::BKGD_BIT];
  assign osc_pin_in         = pin_in[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT +: 2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence dir_d_write_s;
    reg_wr_en && reg_wr_port == spio_pkg::PORT_D && reg_wr_sel == spio_pkg::REG_DIR;
  endsequence

  sequence dir_d_read_s;
    !reg_wr_en && reg_rd_port == spio_pkg::PORT_D && reg_rd_sel == spio_pkg::REG_DIR;
  endsequence

  analog_input_a: assert property (@(posedge clk) disable iff (!reset_n)
    analog_converter_en |-> (pin_oe[spio_pkg::PORT_B] & analog_pin_en) == 8'h00)
    else $error("analog pin driven as output");

  serial_two_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    serial_channel_two_en |-> pin_oe[spio_pkg::PORT_C][0] && !pin_oe[spio_pkg::PORT_C][1]
      && pin_out[spio_pkg::PORT_C][0] == serial_two_transmit)
    else $error("serial two pins not routed");

  i2c_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    i2c_en |-> pin_oe[spio_pkg::PORT_C][2] == i2c_sda_oe && pin_oe[spio_pkg::PORT_C][3] == i2c_scl_oe)
    else $error("I2C pins not routed");

  timer_two_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    timer_unit_two_en[1] |-> pin_oe[spio_pkg::PORT_D][4] == timer_two_ch_oe[1]
      && pin_out[spio_pkg::PORT_D][4] == timer_two_ch_out[1])
    else $error("timer two channel not on bit 4");

  spi_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    spi_en |-> pin_oe[spio_pkg::PORT_E][5:2] == spi_pin_oe && pin_out[spio_pkg::PORT_E][5:2] == spi_pin_out)
    else $error("SPI pins not routed");

  bkgd_pullup_a: assert property (@(posedge clk) disable iff (!reset_n)
    running_q && background_pin_enable |-> pin_pullup_en[spio_pkg::PORT_G][0])
    else $error("background pin pullup not forced");

  mode_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    running_q |=> $stable(mode_select_level))
    else $error("mode-select level changed after capture");

  narrow_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    dir_d_write_s ##1 dir_d_read_s |=> reg_rd_data == ($past(reg_wr_data, 2) & spio_pkg::MASK_D))
    else $error("port d direction readback wrong");

  serial_one_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    serial_channel_one_en |-> pin_oe[spio_pkg::PORT_E][spio_pkg::SER_TX_BIT]
      && !pin_oe[spio_pkg::PORT_E][spio_pkg::SER_RX_BIT]
      && pin_out[spio_pkg::PORT_E][spio_pkg::SER_TX_BIT] == serial_one_transmit)
    else $error("serial one pins not routed");

  timer_one_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    &timer_unit_one_en |-> pin_oe[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT +: 3] == timer_one_ch_oe
      && pin_out[spio_pkg::PORT_D][spio_pkg::TMR1_LO_BIT +: 3] == timer_one_ch_out)
    else $error("timer one channels not on bits 2 to 0");

  osc_pins_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_generator_en |-> pin_oe[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT +: 2] == osc_pin_oe
      && pin_out[spio_pkg::PORT_G][spio_pkg::OSC_LO_BIT +: 2] == osc_pin_out)
    else $error("oscillator pins not routed");

  // the strap must not be disturbed by our own driver before it is captured
  strap_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    !running_q |-> !pin_oe[spio_pkg::PORT_G][spio_pkg::BKGD_BIT]
      && pin_pullup_en[spio_pkg::PORT_G][spio_pkg::BKGD_BIT])
    else $error("mode-select pin driven before capture");

  debug_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd_port == spio_pkg::PORT_G && reg_rd_sel == spio_pkg::REG_DATA
      |=> reg_rd_data[spio_pkg::BKGD_BIT] == $past(pin_in[spio_pkg::PORT_G][spio_pkg::BKGD_BIT]))
    else $error("debug-port bit 0 read not from the pad");

endmodule

// File: tb/spio_pad_model.sv
/*
  Pad model for the shared-pin ports: resolves every pad level from the port drive,
  an external driver and the pullup.
  Assumes the bench drives ext_en and ext_val at the falling edge.
*/
`timescale 1ns/1ns

module spio_pad_model (
  // clock
  input  wire logic            clk,
  // port side
  input  wire logic [5:0][7:0] pin_out,
  input  wire logic [5:0][7:0] pin_oe,
  input  wire logic [5:0][7:0] pin_pullup_en,
  // external drivers
  input  wire logic [5:0][7:0] ext_en,
  input  wire logic [5:0][7:0] ext_val,
  output logic      [5:0][7:0] pin_in
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  logic [7:0] float_q = 8'h55;

  // a floating pad toggles every cycle so a stale level never passes for a read
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pin_in[p] = (pin_oe[p] & pin_out[p]) | (~pin_oe[p] & ext_en[p] & ext_val[p])
                | (~pin_oe[p] & ~ext_en[p] & (pin_pullup_en[p] | float_q));
    end
  end
endmodule

// File: tb/spio_top_tb.sv
/*
  Testbench for the shared-pin ports: register tasks, pad checks, peripheral ownership.
  Assumes the pad model stands on every pad; peripheral signals are plain bench levels.
*/
`timescale 1ns/1ns

module spio_top_tb;
  // ----------------------------------------------------------------
  // stimulus, tables and tasks
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK [6] = '{spio_pkg::MASK_A, spio_pkg::MASK_B, spio_pkg::MASK_C,
                                     spio_pkg::MASK_D, spio_pkg::MASK_E, spio_pkg::MASK_G};
  localparam int         TP   [9] = '{1, 2, 2, 3, 3, 4, 4, 5, 5};
  localparam logic [7:0] TOE  [9] = '{8'ha5, 8'hfd, 8'hfb, 8'h0f, 8'h1a, 8'h3d, 8'h17, 8'h0e, 8'h0d};
  localparam logic [7:0] TOUT [9] = '{8'ha5, 8'hfc, 8'hf3, 8'h07, 8'h18, 8'h3c, 8'h03, 8'h0e, 8'h09};
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            reg_wr_en = 1'b0;
  logic [2:0]      reg_wr_port = 3'h0;
  logic [2:0]      reg_rd_port = 3'h0;
  logic [1:0]      reg_wr_sel = 2'h0;
  logic [1:0]      reg_rd_sel = 2'h0;
  logic [7:0]      reg_wr_data = 8'h00;
  logic [7:0]      reg_rd_data;
  logic [5:0][7:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_slew_en;
  logic [5:0][7:0] ext_en = '0;
  logic [5:0][7:0] ext_val = '0;
  logic [8:0]      en = 9'h080;
  logic            po = 1'b0;
  logic            rx2, sda_i, scl_i, clk2_i, clk1_i, rx1, bkgd_i, ms;
  logic [7:0]      apin = 8'h5a;
  logic            bg_oe = 1'b1;
  logic [1:0]      osc_oe = 2'b10;
  logic [1:0]      t2_i, osc_i;
  logic [2:0]      t1_i;
  logic [3:0]      spi_i;
  int              err_count = 0;
  int              checked = 0;

  always #4 clk = ~clk;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] p, input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    {reg_wr_en, reg_wr_port, reg_wr_sel, reg_wr_data} = {1'b1, p, s, d};
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [2:0] p, input logic [1:0] s, input logic [7:0] exp);
    @(negedge clk);
    reg_rd_port = p;
    reg_rd_sel = s;
    @(negedge clk);
    chk("reg_rd_data", reg_rd_data, exp);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  spio_pad_model pads (.clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in);

  spio_top DUT (.clk, .reset_n, .reg_wr_en, .reg_wr_port, .reg_wr_sel, .reg_wr_data, .reg_rd_port,
    .reg_rd_sel, .reg_rd_data, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .pin_slew_en,
    .analog_converter_en(en[0]), .analog_pin_en(apin), .serial_channel_two_en(en[1]),
    .serial_two_transmit(po), .serial_two_receive(rx2), .i2c_en(en[2]), .i2c_sda_out(po),
    .i2c_sda_oe(1'b0), .i2c_scl_out(po), .i2c_scl_oe(1'b1), .i2c_sda_in(sda_i), .i2c_scl_in(scl_i),
    .timer_unit_two_en({2{en[3]}}), .timer_two_ch_out({2{po}}), .timer_two_ch_oe(2'b01),
    .timer_two_ch_in(t2_i), .timer_two_ext_clk(clk2_i), .timer_unit_one_en({3{en[4]}}),
    .timer_one_ch_out({3{po}}), .timer_one_ch_oe(3'b010), .timer_one_ch_in(t1_i),
    .timer_one_ext_clk(clk1_i), .serial_channel_one_en(en[5]), .serial_one_transmit(po),
    .serial_one_receive(rx1), .spi_en(en[6]), .spi_pin_out({4{po}}), .spi_pin_oe(4'b0101),
    .spi_pin_in(spi_i), .background_pin_enable(en[7]), .background_out(po), .background_oe(bg_oe),
    .background_in(bkgd_i), .mode_select_level(ms), .clock_generator_en(en[8]),
    .osc_pin_out({2{po}}), .osc_pin_oe(osc_oe), .osc_pin_in(osc_i));

  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    ext_en[5][0] = 1'b1;
    ext_val[5][0] = 1'b1;
    repeat (3) @(negedge clk);
    chk("pu_g_rst", pin_pullup_en[5], 8'h01);
    chk("oe_a_rst", pin_oe[0], 8'h00);
    chk("oe_g_rst", pin_oe[5], 8'h00);
    repeat (13) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("mode_sel", {7'h00, ms}, 8'h01);
    chk("bkgd_oe", pin_oe[5], 8'h01);
    ext_en[5][0] = 1'b0;
    bg_oe = 1'b0;
    #1 chk("bkgd_in", {7'h00, bkgd_i}, 8'h01);
    rd(3'h0, spio_pkg::REG_DIR, 8'h00);
    rd(3'h0, spio_pkg::REG_PULLUP, 8'h00);
    ext_en[0] = 8'h0f;
    ext_val[0] = 8'h03;
    // latch first, then direction, so no stale level reaches the pads
    wr(3'h0, spio_pkg::REG_DATA, 8'ha5);
    wr(3'h0, spio_pkg::REG_DIR, 8'hf0);
    chk("oe_a", pin_oe[0], 8'hf0);
    chk("out_a", pin_out[0] & 8'hf0, 8'ha0);
    rd(3'h0, spio_pkg::REG_DATA, 8'ha3);
    wr(3'h0, spio_pkg::REG_PULLUP, 8'hff);
    wr(3'h0, spio_pkg::REG_SLEW, 8'hff);
    chk("pu_a", pin_pullup_en[0], 8'h0f);
    chk("slew_a", pin_slew_en[0], 8'hf0);
    rd(3'h0, spio_pkg::REG_PULLUP, 8'hff);
    rd(3'h0, spio_pkg::REG_SLEW, 8'hff);
    en = 9'h000;
    for (int p = 0; p < 6; p++) begin
      wr(3'(p), spio_pkg::REG_DATA, 8'hff);
      wr(3'(p), spio_pkg::REG_DIR, 8'hff);
      rd(3'(p), spio_pkg::REG_DATA, MASK[p]);
      chk("oe_mask", pin_oe[p], MASK[p]);
    end
    wr(3'h6, spio_pkg::REG_DATA, 8'h00);
    rd(3'h0, spio_pkg::REG_DATA, 8'hff);
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      en = 9'h001 << i;
      #1 chk("own_oe", pin_oe[TP[i]], TOE[i]);
      chk("own_out", pin_out[TP[i]] & TOE[i], TOUT[i]);
    end
    en = 9'h002;
    ext_en[2] = 8'h02;
    ext_val[2] = 8'h02;
    wr(3'h2, spio_pkg::REG_DATA, 8'h00);
    chk("rx_two", {7'h00, rx2}, 8'h01);
    rd(3'h2, spio_pkg::REG_DATA, 8'h00);
    en = 9'h018;
    ext_en[3] = 8'h01;
    ext_val[3] = 8'h01;
    #1 chk("ext_clk_one", {7'h00, clk1_i}, 8'h01);
    en = 9'h080;
    ext_en[5] = 8'h01;
    ext_val[5] = 8'h00;
    rd(3'h5, spio_pkg::REG_DATA, 8'h0e);
    en = 9'h000;
    #1 chk("out_c", pin_out[2], 8'h00);
    // driven latches loop back through the pads to the peripheral inputs
    wr(3'h2, spio_pkg::REG_DATA, 8'h0a);
    wr(3'h3, spio_pkg::REG_DATA, 8'h15);
    wr(3'h4, spio_pkg::REG_DATA, 8'h26);
    wr(3'h5, spio_pkg::REG_DATA, 8'h04);
    chk("pin_back_a", {rx2, sda_i, scl_i, clk2_i, clk1_i, rx1, bkgd_i, 1'b0}, 8'hac);
    chk("pin_back_b", {t1_i, t2_i, osc_i, 1'b0}, 8'hb4);
    chk("spi_back", {4'h0, spi_i}, 8'h09);
    rd(3'h3, spio_pkg::REG_DIR, 8'h1f);
    wr(3'h3, spio_pkg::REG_DIR, 8'he7);
    rd(3'h3, spio_pkg::REG_DIR, 8'h07);
    report_and_stop();
  end
endmodule
